// ==== hw/msadc_pkg.sv ====
// constants and state codes for the multislope converter sequencer
package msadc_pkg;
  // ********************
  // timing
  // ********************
  localparam int  CLK_NS   = 10;
  localparam real TICK_US  = 1.6;
  localparam int  TICK_CYC = $rtoi(TICK_US * 1000.0 / CLK_NS + 0.5);
  localparam real OVH_US   = 1.333;
  localparam int  OVH_CYC  = $rtoi($floor(OVH_US * 1000.0 / CLK_NS));
  localparam real SMP_US   = 51.2;
  localparam int  IVL_NORM = $rtoi(SMP_US / TICK_US + 0.5);
  // ********************
  // phase lengths in counts, accumulator width and step weights
  // ********************
  localparam int AZ_CNT    = 125;
  localparam int INT_CNT   = 307;
  localparam int D1_CNT    = 64;
  localparam int D2_CNT    = 24;
  localparam int IVL_FIRST = 16;
  localparam int IVL_LAST  = 35;
  localparam int IVL_NUM   = 8;
  localparam int ACC_W     = 20;
  localparam int CRS_STEP  = 16;
  localparam int FINE_STEP = 1;
  // ********************
  // sequencer states
  // ********************
  typedef enum logic [10:0] {
    ST_IDLE = 11'h001, ST_AZ  = 11'h002, ST_INT = 11'h004, ST_D1P = 11'h008,
    ST_D1H  = 11'h010, ST_D1N = 11'h020, ST_D1G = 11'h040, ST_D1R = 11'h080,
    ST_D1F  = 11'h100, ST_D2  = 11'h200, ST_OVH = 11'h400
  } msadc_state_t;
endpackage : msadc_pkg

// ==== hw/msadc_seq.sv ====
// multislope converter sequencer: phase timing, switch drive, counts, serial readout
// Notes on behaviour
// - idle autozero keeps all references and input off
// - autozero 125 counts, integrate 307, then deintegrate
// - integrate: input on, autozero and fine off
// - comparator sampled each interval start, 51.2 us
// - positive and negative never on together
// - interval start: references off one count
// - then one balancing pulse keeps pulse totals equal
// - rest of interval: comparator-picked reference
// - intervals 16, eight of 32, last 35
// - separate positive and negative on-time counters
// - integrate ends off; deintegrate1 starts positive
// - deintegrate1 holds once comparator goes low
// - after hold, negative until comparator low
// - one-count hold, positive until comparator high
// - references off until 64 counts elapsed
// - fine reference credited at one sixteenth weight
// - comparator low turns the deintegrate2 fine reference off
// - deintegrate2 always lasts 24 counts
// - fixed 133-clock (1.33 us) overhead ends each cycle
// - two 20-bit totals delivered during autozero
// - three-line serial link: clock, transmit, receive
`timescale 1ns/10ps
module msadc_seq #(
  parameter int ACC_W = msadc_pkg::ACC_W
) (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic conv_trigger_n,
  input  wire logic zero_cross_detect,
  input  wire logic serial_bus_clock,
  input  wire logic serial_bus_rx,
  output logic      serial_bus_tx,
  output logic      pos_ref_switch,
  output logic      neg_ref_switch,
  output logic      fine_ref_switch,
  output logic      input_connect,
  output logic      autozero_ctl,
  output logic      result_ready
);
  localparam int SH_W = 2 * ACC_W;

  // length of integrate interval by index
  function automatic logic [5:0] ivl_len(input logic [3:0] idx);
    if (idx == 4'h0) return 6'(msadc_pkg::IVL_FIRST);
    if (idx == 4'(msadc_pkg::IVL_NUM + 1)) return 6'(msadc_pkg::IVL_LAST);
    return 6'(msadc_pkg::IVL_NORM);
  endfunction : ivl_len

  // ********************
  // input synchronisers
  // ********************
  logic [3:0] s1_reg;
  logic [3:0] s2_reg;
  logic       sck_d_reg;
  logic       trg_d_reg;
  // two flops per pin: trigger, comparator, serial clock, serial receive
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg    <= 4'hF;
      s2_reg    <= 4'hF;
      sck_d_reg <= 1'b1;
      trg_d_reg <= 1'b1;
    end else begin
      s1_reg    <= {conv_trigger_n, zero_cross_detect, serial_bus_clock, serial_bus_rx};
      s2_reg    <= s1_reg;
      sck_d_reg <= s2_reg[1];
      trg_d_reg <= s2_reg[3];
    end
  end
  logic trg_s, cmp_s, sck_s, rx_s;
  assign {trg_s, cmp_s, sck_s, rx_s} = s2_reg;

  // ********************
  // sequencer state
  // ********************
  msadc_pkg::msadc_state_t state_reg, state_next;
  logic [7:0]       div_reg, div_next;
  logic [8:0]       cnt_reg, cnt_next;
  logic [3:0]       ivl_reg, ivl_next;
  logic [5:0]       pin_reg, pin_next;
  logic             pick_reg, pick_next;
  logic signed [5:0] bal_reg, bal_next;
  logic             pos_reg, pos_next;
  logic             neg_reg, neg_next;
  logic             fine_reg, fine_next;
  logic             inp_reg, inp_next;
  logic             az_reg, az_next;
  logic [ACC_W-1:0] pacc_reg, pacc_next;
  logic [ACC_W-1:0] nacc_reg, nacc_next;
  logic [7:0]       ovh_reg, ovh_next;
  logic [SH_W-1:0]  sh_reg, sh_next;
  logic             tx_reg, tx_next;
  logic             rdy_reg, rdy_next;
  logic             tick, in_d1, bal_pos;

  assign tick = (div_reg == 8'(msadc_pkg::TICK_CYC - 1));
  assign in_d1 = state_reg inside {msadc_pkg::ST_D1P, msadc_pkg::ST_D1H, msadc_pkg::ST_D1N,
                                   msadc_pkg::ST_D1G, msadc_pkg::ST_D1R, msadc_pkg::ST_D1F};
  // balancing polarity: behind on positive pulses, or tie goes against the pick
  assign bal_pos = (bal_reg < 0) || ((bal_reg == 0) && !pick_reg);

  // next-state, switch and counter logic
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    ivl_next   = ivl_reg;
    pin_next   = pin_reg;
    pick_next  = pick_reg;
    bal_next   = bal_reg;
    pos_next   = pos_reg;
    neg_next   = neg_reg;
    fine_next  = fine_reg;
    inp_next   = inp_reg;
    az_next    = az_reg;
    pacc_next  = pacc_reg;
    nacc_next  = nacc_reg;
    ovh_next   = ovh_reg;
    sh_next    = sh_reg;
    rdy_next   = rdy_reg;
    div_next   = (state_reg inside {msadc_pkg::ST_IDLE, msadc_pkg::ST_OVH} || tick)
                 ? 8'h00 : div_reg + 8'h01;
    // on-time accumulation for the count just ending
    if (tick) begin
      if (pos_reg) pacc_next = pacc_reg + ACC_W'(msadc_pkg::CRS_STEP);
      if (neg_reg) nacc_next = nacc_reg + ACC_W'(msadc_pkg::CRS_STEP);
      if (fine_reg) nacc_next = nacc_reg + ACC_W'(msadc_pkg::FINE_STEP);
      cnt_next = cnt_reg + 9'h001;
    end
    unique case (state_reg)
      msadc_pkg::ST_IDLE: begin
        {pos_next, neg_next, fine_next, inp_next} = 4'h0;
        az_next = 1'b1;
        if (!trg_s && trg_d_reg) begin
          state_next = msadc_pkg::ST_AZ;
          cnt_next   = 9'h000;
          pacc_next  = '0;
          nacc_next  = '0;
          rdy_next   = 1'b0;
        end
      end
      msadc_pkg::ST_AZ: begin
        if (tick && cnt_reg == 9'(msadc_pkg::AZ_CNT - 1)) begin
          state_next = msadc_pkg::ST_INT;
          cnt_next   = 9'h000;
          ivl_next   = 4'h0;
          pin_next   = 6'h00;
          bal_next   = '0;
          pick_next  = cmp_s;
          az_next    = 1'b0;
          inp_next   = 1'b1;
        end
      end
      msadc_pkg::ST_INT: begin
        if (tick) begin
          pin_next = pin_reg + 6'h01;
          if (cnt_reg == 9'(msadc_pkg::INT_CNT - 1)) begin
            state_next = msadc_pkg::ST_D1P;
            cnt_next   = 9'h000;
            inp_next   = 1'b0;
            pos_next   = 1'b1;
          end else if (cnt_reg == 9'(msadc_pkg::INT_CNT - 2)) begin
            {pos_next, neg_next} = 2'b00;
          end else if (pin_reg == ivl_len(ivl_reg) - 6'h01) begin
            ivl_next  = ivl_reg + 4'h1;
            pin_next  = 6'h00;
            pick_next = cmp_s;
            {pos_next, neg_next} = 2'b00;
          end else if (pin_reg == 6'h00) begin
            pos_next = bal_pos;
            neg_next = !bal_pos;
            bal_next = bal_pos ? bal_reg + 6'sd1 : bal_reg - 6'sd1;
          end else if (pin_reg == 6'h01) begin
            pos_next = pick_reg;
            neg_next = !pick_reg;
            bal_next = pick_reg ? bal_reg + 6'sd1 : bal_reg - 6'sd1;
          end
        end
      end
      msadc_pkg::ST_D1P: begin
        if (tick && !cmp_s) begin
          state_next = msadc_pkg::ST_D1H;
          pos_next   = 1'b0;
        end
      end
      msadc_pkg::ST_D1H: begin
        if (tick) begin
          state_next = msadc_pkg::ST_D1N;
          neg_next   = 1'b1;
        end
      end
      msadc_pkg::ST_D1N: begin
        if (tick && !cmp_s) begin
          state_next = msadc_pkg::ST_D1G;
          neg_next   = 1'b0;
        end
      end
      msadc_pkg::ST_D1G: begin
        if (tick) begin
          state_next = msadc_pkg::ST_D1R;
          pos_next   = 1'b1;
        end
      end
      msadc_pkg::ST_D1R: begin
        if (tick && cmp_s) begin
          state_next = msadc_pkg::ST_D1F;
          pos_next   = 1'b0;
        end
      end
      msadc_pkg::ST_D1F: {pos_next, neg_next} = 2'b00;
      msadc_pkg::ST_D2: begin
        if (tick && !cmp_s) fine_next = 1'b0;
        if (tick && cnt_reg == 9'(msadc_pkg::D2_CNT - 1)) begin
          state_next = msadc_pkg::ST_OVH;
          fine_next  = 1'b0;
          ovh_next   = 8'h00;
        end
      end
      msadc_pkg::ST_OVH: begin
        ovh_next = ovh_reg + 8'h01;
        if (ovh_reg == 8'(msadc_pkg::OVH_CYC - 1)) begin
          state_next = msadc_pkg::ST_IDLE;
          az_next    = 1'b1;
          rdy_next   = 1'b1;
        end
      end
      default: state_next = msadc_pkg::ST_IDLE; // illegal code falls back to idle
    endcase
    // deintegrate1 ends at a fixed total, whatever sub-step is running
    if (in_d1 && tick && cnt_reg == 9'(msadc_pkg::D1_CNT - 1)) begin
      state_next = msadc_pkg::ST_D2;
      cnt_next   = 9'h000;
      {pos_next, neg_next} = 2'b00;
      fine_next  = 1'b1;
    end
    // result shifts out msb first on each serial clock rise, receive fills in
    if (state_reg == msadc_pkg::ST_OVH && ovh_reg == 8'(msadc_pkg::OVH_CYC - 1)) begin
      sh_next = {pacc_reg, nacc_reg};
    end else if (sck_s && !sck_d_reg) begin
      sh_next = {sh_reg[SH_W-2:0], rx_s};
    end
    tx_next = sh_next[SH_W-1];
  end

  // state registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= msadc_pkg::ST_IDLE;
      div_reg   <= 8'h00;
      cnt_reg   <= 9'h000;
      ivl_reg   <= 4'h0;
      pin_reg   <= 6'h00;
      pick_reg  <= 1'b0;
      bal_reg   <= '0;
      pos_reg   <= 1'b0;
      neg_reg   <= 1'b0;
      fine_reg  <= 1'b0;
      inp_reg   <= 1'b0;
      az_reg    <= 1'b1;
      pacc_reg  <= '0;
      nacc_reg  <= '0;
      ovh_reg   <= 8'h00;
      sh_reg    <= '0;
      tx_reg    <= 1'b0;
      rdy_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      div_reg   <= div_next;
      cnt_reg   <= cnt_next;
      ivl_reg   <= ivl_next;
      pin_reg   <= pin_next;
      pick_reg  <= pick_next;
      bal_reg   <= bal_next;
      pos_reg   <= pos_next;
      neg_reg   <= neg_next;
      fine_reg  <= fine_next;
      inp_reg   <= inp_next;
      az_reg    <= az_next;
      pacc_reg  <= pacc_next;
      nacc_reg  <= nacc_next;
      ovh_reg   <= ovh_next;
      sh_reg    <= sh_next;
      tx_reg    <= tx_next;
      rdy_reg   <= rdy_next;
    end
  end

  // outputs straight from flops
  assign pos_ref_switch  = pos_reg;
  assign neg_ref_switch  = neg_reg;
  assign fine_ref_switch = fine_reg;
  assign input_connect   = inp_reg;
  assign autozero_ctl    = az_reg;
  assign serial_bus_tx   = tx_reg;
  assign result_ready    = rdy_reg;

  // ********************
  // checks
  // ********************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence tick_s;
    tick;
  endsequence
  sequence int_end_s;
    state_reg == msadc_pkg::ST_INT && tick && cnt_reg == 9'(msadc_pkg::INT_CNT - 1);
  endsequence
  sequence d1_start_s;
    state_reg == msadc_pkg::ST_D1P && pos_reg && !inp_reg;
  endsequence
  idle_refs_a: assert property (state_reg == msadc_pkg::ST_IDLE |->
    !pos_reg && !neg_reg && !fine_reg && !inp_reg) else $error("switch on while idle");
  az_len_a: assert property (state_reg == msadc_pkg::ST_AZ && tick &&
    cnt_reg == 9'(msadc_pkg::AZ_CNT - 1) |=> state_reg == msadc_pkg::ST_INT)
    else $error("autozero length wrong");
  int_sw_a: assert property (state_reg == msadc_pkg::ST_INT |->
    inp_reg && !az_reg && !fine_reg) else $error("integrate switches wrong");
  no_both_a: assert property (!(pos_reg && neg_reg))
    else $error("both references on");
  ivl_off_a: assert property (state_reg == msadc_pkg::ST_INT && tick &&
    pin_reg == ivl_len(ivl_reg) - 6'h01 && cnt_reg < 9'(msadc_pkg::INT_CNT - 2)
    |=> !pos_reg && !neg_reg && pin_reg == 6'h00) else $error("no input-only count");
  pick_use_a: assert property (state_reg == msadc_pkg::ST_INT && tick &&
    pin_reg == 6'h01 && cnt_reg < 9'(msadc_pkg::INT_CNT - 2) |=> pos_reg == pick_reg)
    else $error("wrong comparator reference");
  d1_entry_a: assert property (int_end_s |=> d1_start_s)
    else $error("deintegrate1 entry wrong");
  d1_hold_a: assert property (state_reg == msadc_pkg::ST_D1P && tick && !cmp_s &&
    cnt_reg != 9'(msadc_pkg::D1_CNT - 1) |=> state_reg == msadc_pkg::ST_D1H && !pos_reg)
    else $error("no hold on comparator low");
  d2_len_a: assert property (state_reg == msadc_pkg::ST_D2 && tick &&
    cnt_reg == 9'(msadc_pkg::D2_CNT - 1) |=> state_reg == msadc_pkg::ST_OVH && !fine_reg)
    else $error("deintegrate2 length wrong");
  tick_gap_a: assert property (tick_s |=> !tick [*8])
    else $error("count ticks too close");
endmodule : msadc_seq

// ==== dv/msadc_front_model.sv ====
// integrator and comparator model facing the sequencer switches
`timescale 1ns/10ps
module msadc_front_model (
  input  wire logic       sys_clk,
  input  wire logic       input_connect,
  input  wire logic       autozero_ctl,
  input  wire logic       pos_ref_switch,
  input  wire logic       neg_ref_switch,
  input  wire logic       fine_ref_switch,
  input  wire logic [1:0] force_lvl,
  output logic            zero_cross_detect
);
  int acc_reg = 0;
  // charge on the integrator, cleared while autozero is closed
  always @(posedge sys_clk) begin
    if (autozero_ctl)
      acc_reg <= 0;
    else
      acc_reg <= acc_reg + (input_connect ? 3 : 0) - (pos_ref_switch ? 64 : 0)
                 + (neg_ref_switch ? 64 : 0) - (fine_ref_switch ? 4 : 0);
  end
  // comparator, overridden when the bench commands a level
  assign zero_cross_detect = force_lvl[1] ? 1'b1 : (force_lvl[0] ? 1'b0 : (acc_reg > 0));
endmodule : msadc_front_model

// ==== dv/tb_top.sv ====
// self-checking bench for the multislope converter sequencer
`timescale 1ns/10ps
module tb_top;
  logic        sys_clk, reset_n, conv_trigger_n, zero_cross_detect, result_ready;
  logic        serial_bus_clock, serial_bus_rx, serial_bus_tx, input_connect;
  logic        pos_ref_switch, neg_ref_switch, fine_ref_switch, autozero_ctl;
  logic [1:0]  force_lvl;
  logic [3:0]  sw_log [0:394];
  logic [39:0] rd_bits;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          t_trig = 0;
  int          t_int = 0;
  int          t_rdy = 0;

  msadc_seq dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .conv_trigger_n(conv_trigger_n),
    .zero_cross_detect(zero_cross_detect), .serial_bus_clock(serial_bus_clock),
    .serial_bus_rx(serial_bus_rx), .serial_bus_tx(serial_bus_tx),
    .pos_ref_switch(pos_ref_switch), .neg_ref_switch(neg_ref_switch),
    .fine_ref_switch(fine_ref_switch), .input_connect(input_connect),
    .autozero_ctl(autozero_ctl), .result_ready(result_ready)
  );
  msadc_front_model model (
    .sys_clk(sys_clk), .input_connect(input_connect), .autozero_ctl(autozero_ctl),
    .pos_ref_switch(pos_ref_switch), .neg_ref_switch(neg_ref_switch),
    .fine_ref_switch(fine_ref_switch), .force_lvl(force_lvl),
    .zero_cross_detect(zero_cross_detect)
  );

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // cycle count, timeout, switch snapshot in the middle of each count
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (input_connect === 1'b1 && t_int == 0) t_int <= cyc;
    if (result_ready === 1'b1 && t_int > 0 && t_rdy == 0) t_rdy <= cyc;
    if (t_int > 0 && (cyc - t_int) % 160 == 80 && cyc - t_int < 63200)
      sw_log[(cyc - t_int) / 160] <= {input_connect, pos_ref_switch, neg_ref_switch,
                                      fine_ref_switch};
    if (cyc == 90000) begin
      n_mismatch++;
      $display("wrong value at %0t: run did not finish", $time);
      report_and_stop();
    end
  end

  // ********************
  // helpers
  // ********************
  function automatic logic [5:0] sw_vec();
    return {input_connect, pos_ref_switch, neg_ref_switch, fine_ref_switch, autozero_ctl,
            result_ready};
  endfunction : sw_vec

  task automatic chk_val(logic [19:0] got, logic [19:0] exp, string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_val

  task automatic chk_time(int d, int lo, int hi, string what);
    samples_checked++;
    if (d < lo || d > hi) begin
      n_mismatch++;
      $display("wrong value at %0t: %s took %0d", $time, what, d);
    end
  endtask : chk_time

  task automatic wait_cyc(int c);
    while (cyc < c) @(negedge sys_clk);
  endtask : wait_cyc

  task automatic pulse_trigger();
    conv_trigger_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    conv_trigger_n = 1'b1;
  endtask : pulse_trigger

  // ********************
  // scenarios
  // ********************
  // reset and idle levels of every switch
  task automatic chk_reset();
    repeat (5) @(negedge sys_clk);
    chk_val(sw_vec(), 6'h02, "reset state");
    reset_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk_val(sw_vec(), 6'h02, "idle state");
  endtask : chk_reset

  // one conversion with a stray trigger and comparator flips in both deintegrates
  task automatic run_cycle();
    force_lvl = 2'h2;
    t_trig = cyc;
    pulse_trigger();
    while (t_int == 0) @(negedge sys_clk);
    wait_cyc(t_int + 160 * 100);
    pulse_trigger();
    wait_cyc(t_int + 160 * 317);
    force_lvl = 2'h1;
    wait_cyc(t_int + 160 * 337);
    force_lvl = 2'h2;
    wait_cyc(t_int + 160 * 381);
    force_lvl = 2'h1;
    while (t_rdy == 0) @(negedge sys_clk);
    chk_time(t_int - t_trig, 20001, 20007, "autozero");
    chk_time(t_rdy - t_int, 63332, 63334, "cycle");
  endtask : run_cycle

  // integrate pattern with the comparator held high
  task automatic chk_integrate();
    int k;
    logic [1:0] e;
    for (int t = 0; t < 307; t++) begin
      k = (t < 16) ? t : ((t < 272) ? (t - 16) % 32 : t - 272);
      e = (k == 0 || t == 306) ? 2'h0 : ((k == 1) ? 2'h1 : 2'h2);
      chk_val(sw_log[t], {1'h1, e, 1'h0}, "integrate");
    end
  endtask : chk_integrate

  // deintegrate steps: holds between polarities, final hold, fine phase
  task automatic chk_deint();
    logic [19:0] bad;
    logic [19:0] negs;
    bad = 20'h0;
    negs = 20'h0;
    for (int t = 307; t < 371; t++) begin
      bad += sw_log[t][3] | sw_log[t][0] | (sw_log[t][2] & sw_log[t][1])
             | (sw_log[t-1][2] & sw_log[t][1]) | (sw_log[t-1][1] & sw_log[t][2]);
      negs += sw_log[t][1];
      if (t > 340) bad += |sw_log[t];
    end
    chk_val(sw_log[307], 4'h4, "deintegrate start");
    chk_val(sw_log[315], 4'h4, "positive while high");
    chk_val(bad, 20'h0, "deintegrate holds");
    chk_val(negs > 0, 1'h1, "negative slope");
    chk_val(sw_log[371], 4'h1, "fine start");
    chk_val(sw_log[386] | sw_log[394], 4'h0, "fine stop");
  endtask : chk_deint

  // shift out the 40 result bits while autozero holds
  task automatic read_result();
    int p;
    int n;
    rd_bits[39] = serial_bus_tx;
    for (int i = 38; i >= 0; i--) begin
      serial_bus_clock = 1'b1;
      serial_bus_rx = i[0];
      repeat (6) @(negedge sys_clk);
      rd_bits[i] = serial_bus_tx;
      serial_bus_clock = 1'b0;
      repeat (6) @(negedge sys_clk);
    end
    p = 0;
    n = 0;
    for (int t = 0; t < 395; t++) begin
      p += 16 * sw_log[t][2];
      n += 16 * sw_log[t][1] + sw_log[t][0];
    end
    chk_val(rd_bits[39:20], p[19:0], "positive total");
    chk_val(rd_bits[19:0], n[19:0], "negative total");
    chk_val(sw_vec(), 6'h03, "idle after cycle");
  endtask : read_result

  task automatic report_and_stop();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // main sequence
  initial begin
    reset_n = 1'b0;
    conv_trigger_n = 1'b1;
    serial_bus_clock = 1'b0;
    serial_bus_rx = 1'b0;
    force_lvl = 2'h2;
    chk_reset();
    run_cycle();
    chk_integrate();
    chk_deint();
    read_result();
    report_and_stop();
  end
endmodule : tb_top
